// ===== rtl/ebr_ctrl.sv
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "ebr_defines.svh"

// Notes on behaviour
// R1 - Read data latched on the same edge that ends the strobe and moves address. Here latched one core clock before the strobe rises.
// R2 - Ready high at sampling adds a wait state; ready low ends the cycle.
// R3 - Responder may drop ready after the strobe trailing edge.
// R4 - Unsynchronised ready must stay low two clock phases plus 10 ns.
// R5 - Multiplexed mode appends a mux wait, then optional tristate wait.
// R6 - Cycle runs its programmed memory wait states before ready is sampled.
// R7 - Read/write delay option moves the strobe leading edge later.
// R8 - No new cycle until post-cycle mux and tristate waits finish.
// R9 - Hold request is granted only after the running cycle ends.
// R10 - Regaining the bus starts only when hold request returns high.
// R11 - Sync ready sampled directly; async ready passes a two-stage synchroniser. Here sync ready passes one flip-flop, async ready three.
module ebr_ctrl (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic        link_clk,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             system_clock_output,
   output logic [7:0]       bus_addr,
   output logic [15:0]      bus_dout,
   output logic             bus_dout_oe,
   input  wire logic [15:0] bus_din,
   output logic             rd_n,
   output logic             wr_n,
   output logic             ale,
   output logic             chip_select_outputs_n,
   input  wire logic        ready_n,
   input  wire logic        hold_n,
   output logic             hold_acknowledge_out_n,
   output logic             bus_regain_request_n,
   output logic             link_busy
);
   // -------------------------------------------------------------------
   // Register access.
   // -------------------------------------------------------------------
   logic [31:0]          ctrl_reg;
   logic [15:0]          rdata_reg;
   logic                 done_reg;
   logic                 pend_reg;
   ebr_pkg::ebr_cmd_s    cmd_reg;
   ebr_pkg::ebr_state_e  st_reg;
   ebr_pkg::ebr_state_e  st_next;
   logic [3:0]           wcnt_reg;
   logic [3:0]           ck_reg;
   logic                 clko_reg;
   logic                 tick;
   logic                 h1_reg;
   logic                 h2_reg;
   logic                 done_set;

   wire acc        = psel && penable;
   wire wr_acc     = acc && pwrite;
   wire sel_ctrl   = paddr == `EBR_CTRL_OFS;
   wire sel_cmd    = paddr == `EBR_CMD_OFS;
   wire sel_stat   = paddr == `EBR_STAT_OFS;
   wire sel_rdat   = paddr == `EBR_RDATA_OFS;
   wire mapped     = sel_ctrl || sel_cmd || sel_stat || sel_rdat;
   wire busy       = pend_reg || ((st_reg != ebr_pkg::EBR_IDLE) &&
                                  (st_reg != ebr_pkg::EBR_HOLD));
   wire [3:0] mcwc = ctrl_reg[`EBR_CTRL_MCWC_MSB:`EBR_CTRL_MCWC_LSB];
   wire mux_mode   = ctrl_reg[`EBR_CTRL_MUX_BIT];
   wire tri_opt    = ctrl_reg[`EBR_CTRL_TRI_BIT];
   wire rw_delay   = ctrl_reg[`EBR_CTRL_RWD_BIT];
   wire hold_req   = !h2_reg;
   wire cmd_write  = wr_acc && sel_cmd && !busy;

   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;

   wire [31:0] stat_word = {29'h0000_0000, done_reg, !hold_acknowledge_out_n, busy};
   wire [31:0] rd_mux    = sel_ctrl ? ctrl_reg :
                           sel_cmd  ? {cmd_reg.dat, 7'h00, cmd_reg.wr, cmd_reg.adr} :
                           sel_stat ? stat_word :
                           sel_rdat ? {16'h0000, rdata_reg} : 32'h0000_0000;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= rd_mux;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= `EBR_CTRL_RST;
      end else if (wr_acc && sel_ctrl) begin
         ctrl_reg <= pwdata;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cmd_reg <= '0;
      end else if (cmd_write) begin
         cmd_reg <= {pwdata[`EBR_CMD_WR_BIT], pwdata[`EBR_CMD_ADR_MSB:`EBR_CMD_ADR_LSB],
                     pwdata[`EBR_CMD_DAT_MSB:`EBR_CMD_DAT_LSB]};
      end
   end

   // -------------------------------------------------------------------
   // Clock output generator and pin synchronisers.
   // -------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ck_reg   <= 4'h0;
         clko_reg <= 1'b0;
      end else if (ck_reg == `EBR_SYSTEM_CLOCK_OUTPUT_HALF) begin
         ck_reg   <= 4'h0;
         clko_reg <= !clko_reg;
      end else begin
         ck_reg   <= ck_reg + 4'h1;
      end
   end

   // Bus states advance once per clock-output period, at its rising edge.
   assign tick                = (ck_reg == `EBR_SYSTEM_CLOCK_OUTPUT_HALF) && !clko_reg;
   assign system_clock_output = clko_reg;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         h1_reg <= 1'b1;
         h2_reg <= 1'b1;
      end else begin
         h1_reg <= hold_n;
         h2_reg <= h1_reg;
      end
   end

   ebr_rdy_if rif ();
   assign rif.rdy_pin    = ready_n;
   assign rif.async_mode = ctrl_reg[`EBR_CTRL_ASY_BIT];

   ebr_ready_sync u_rdy (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .rif      (rif)
   );

   // Ready pin is active low: high requests another wait state.
   wire rdy_wait = rif.rdy_sync;

   // -------------------------------------------------------------------
   // Bus cycle sequencer.
   // -------------------------------------------------------------------
   wire mcw_done = wcnt_reg == mcwc;

   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         ebr_pkg::EBR_IDLE: begin
            if (hold_req) begin
               st_next = ebr_pkg::EBR_HOLD; // R9
            end else if (pend_reg) begin
               st_next = ebr_pkg::EBR_ADDR;
            end
         end
         ebr_pkg::EBR_ADDR: begin
            st_next = rw_delay ? ebr_pkg::EBR_WAIT : ebr_pkg::EBR_STRB; // R7
         end
         ebr_pkg::EBR_WAIT: begin
            st_next = ebr_pkg::EBR_STRB;
         end
         ebr_pkg::EBR_STRB: begin
            if (mcw_done && !rdy_wait) begin // R6 R2
               st_next = mux_mode ? ebr_pkg::EBR_MUXW : ebr_pkg::EBR_IDLE; // R5
            end
         end
         ebr_pkg::EBR_MUXW: begin
            st_next = tri_opt ? ebr_pkg::EBR_TRIW : ebr_pkg::EBR_IDLE; // R5 R8
         end
         ebr_pkg::EBR_TRIW: begin
            st_next = ebr_pkg::EBR_IDLE; // R8
         end
         ebr_pkg::EBR_HOLD: begin
            if (!hold_req) begin
               st_next = ebr_pkg::EBR_IDLE; // R10
            end
         end
         default: begin
            st_next = ebr_pkg::EBR_IDLE;
         end
      endcase
   end

   wire strobe_end = tick && (st_reg == ebr_pkg::EBR_STRB) && (st_next != ebr_pkg::EBR_STRB);
   assign done_set = strobe_end;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= ebr_pkg::EBR_IDLE;
      end else if (tick) begin
         st_reg <= st_next;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wcnt_reg <= 4'h0;
      end else if (tick) begin
         // The count stays at its limit while ready stretches the strobe.
         wcnt_reg <= (st_reg != ebr_pkg::EBR_STRB) ? 4'h0 :
                     mcw_done ? wcnt_reg : wcnt_reg + 4'h1; // R6
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pend_reg <= 1'b0;
      end else if (cmd_write) begin
         pend_reg <= 1'b1;
      end else if (tick && st_reg == ebr_pkg::EBR_IDLE && !hold_req) begin
         pend_reg <= 1'b0;
      end
   end

   // Data are taken at the edge that ends the strobe state, one core clock before the strobe rises and the address drops.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg <= 16'h0000;
      end else if (strobe_end && !cmd_reg.wr) begin
         rdata_reg <= bus_din; // R1
      end
   end

   // Done is set by a finished cycle and cleared by a new command; set wins.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         done_reg <= 1'b0;
      end else if (done_set) begin
         done_reg <= 1'b1;
      end else if (cmd_write) begin
         done_reg <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Pin drivers.
   // -------------------------------------------------------------------
   wire in_cyc = (st_reg == ebr_pkg::EBR_ADDR) || (st_reg == ebr_pkg::EBR_WAIT) ||
                 (st_reg == ebr_pkg::EBR_STRB);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus_addr               <= 8'h00;
         bus_dout               <= 16'h0000;
         bus_dout_oe            <= 1'b0;
         rd_n                   <= 1'b1;
         wr_n                   <= 1'b1;
         ale                    <= 1'b0;
         chip_select_outputs_n  <= 1'b1;
         hold_acknowledge_out_n <= 1'b1;
         bus_regain_request_n   <= 1'b1;
      end else begin
         bus_addr               <= in_cyc ? cmd_reg.adr : 8'h00;
         bus_dout               <= cmd_reg.dat;
         bus_dout_oe            <= in_cyc && cmd_reg.wr;
         rd_n                   <= !(st_reg == ebr_pkg::EBR_STRB && !cmd_reg.wr); // R7
         wr_n                   <= !(st_reg == ebr_pkg::EBR_STRB && cmd_reg.wr); // R7
         ale                    <= st_reg == ebr_pkg::EBR_ADDR;
         chip_select_outputs_n  <= !in_cyc;
         hold_acknowledge_out_n <= st_reg != ebr_pkg::EBR_HOLD; // R9
         bus_regain_request_n   <= !(st_reg == ebr_pkg::EBR_HOLD && pend_reg);
      end
   end

   // -------------------------------------------------------------------
   // Link clock domain: busy level crossed by two flip-flops.
   // -------------------------------------------------------------------
   logic busy_reg;
   logic lb1_reg;
   logic lb2_reg;

   // A registered copy keeps decode glitches out of the crossing.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= busy;
      end
   end

   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         lb1_reg <= 1'b0;
         lb2_reg <= 1'b0;
      end else begin
         lb1_reg <= busy_reg;
         lb2_reg <= lb1_reg;
      end
   end
   assign link_busy = lb2_reg;

   // -------------------------------------------------------------------
   // Checks.
   // -------------------------------------------------------------------
   a_hold_after_cycle: assert property (@(posedge core_clk) disable iff (!arst_n) // R9
      !hold_acknowledge_out_n |-> (rd_n && wr_n))
      else $error("hold granted during a strobe");
   a_hold_release: assert property (@(posedge core_clk) disable iff (!arst_n) // R10
      (st_reg == ebr_pkg::EBR_HOLD && tick && !hold_req) |=> st_reg == ebr_pkg::EBR_IDLE)
      else $error("bus not regained after hold release");
   a_ready_wait: assert property (@(posedge core_clk) disable iff (!arst_n) // R2
      (st_reg == ebr_pkg::EBR_STRB && tick && rdy_wait) |=> st_reg == ebr_pkg::EBR_STRB)
      else $error("cycle ended with ready high");
   a_ready_end: assert property (@(posedge core_clk) disable iff (!arst_n) // R2
      (st_reg == ebr_pkg::EBR_STRB && tick && mcw_done && !rdy_wait)
      |=> st_reg != ebr_pkg::EBR_STRB)
      else $error("cycle not ended with ready low");
   a_mcw_count: assert property (@(posedge core_clk) disable iff (!arst_n) // R6
      (strobe_end) |-> wcnt_reg == mcwc)
      else $error("strobe shorter than programmed wait states");
   a_mux_wait: assert property (@(posedge core_clk) disable iff (!arst_n) // R5
      (strobe_end && mux_mode) |=> st_reg == ebr_pkg::EBR_MUXW)
      else $error("missing multiplex wait state");
   a_tri_wait: assert property (@(posedge core_clk) disable iff (!arst_n) // R8
      (st_reg == ebr_pkg::EBR_MUXW && tick && tri_opt) |=> st_reg == ebr_pkg::EBR_TRIW)
      else $error("missing tristate wait state");
   a_rw_delay: assert property (@(posedge core_clk) disable iff (!arst_n) // R7
      (st_reg == ebr_pkg::EBR_ADDR && tick && rw_delay) |=> st_reg == ebr_pkg::EBR_WAIT)
      else $error("delayed strobe started early");
   a_read_latch: assert property (@(posedge core_clk) disable iff (!arst_n) // R1
      (strobe_end && !cmd_reg.wr) |=> rdata_reg == $past(bus_din))
      else $error("read data not latched at strobe end");
   a_mcw_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // R6
      (st_reg == ebr_pkg::EBR_STRB && tick && mcw_done && rdy_wait) |=> mcw_done)
      else $error("wait count lost during a ready wait state");
   a_regain_req: assert property (@(posedge core_clk) disable iff (!arst_n) // R10
      (st_reg == ebr_pkg::EBR_HOLD && pend_reg) |=> !bus_regain_request_n)
      else $error("bus regain request missing while a command waits");

   c_read_cycle:  cover property (@(posedge core_clk) strobe_end && !cmd_reg.wr);
   c_write_cycle: cover property (@(posedge core_clk) strobe_end && cmd_reg.wr);
   c_tri_state:   cover property (@(posedge core_clk) st_reg == ebr_pkg::EBR_TRIW);
   c_hold_grant:  cover property (@(posedge core_clk) !hold_acknowledge_out_n);
   c_regain_req:  cover property (@(posedge core_clk) !bus_regain_request_n);
endmodule

// ===== pkg/ebr_defines.svh
`ifndef EBR_DEFINES_SVH
`define EBR_DEFINES_SVH

// APB register offsets (byte addresses).
`define EBR_CTRL_OFS      12'h000
`define EBR_CMD_OFS       12'h004
`define EBR_STAT_OFS      12'h008
`define EBR_RDATA_OFS     12'h00C

// Control register field positions.
`define EBR_CTRL_MCWC_LSB 0
`define EBR_CTRL_MCWC_MSB 3
`define EBR_CTRL_MUX_BIT  4
`define EBR_CTRL_TRI_BIT  5
`define EBR_CTRL_RWD_BIT  6
`define EBR_CTRL_ASY_BIT  7
`define EBR_CTRL_RST      32'h0000_0000

// Command register fields: address, write flag, write data.
`define EBR_CMD_ADR_LSB   0
`define EBR_CMD_ADR_MSB   7
`define EBR_CMD_WR_BIT    8
`define EBR_CMD_DAT_LSB   16
`define EBR_CMD_DAT_MSB   31

// Status register field positions.
`define EBR_STAT_BUSY_BIT 0
`define EBR_STAT_HOLD_ACKNOWLEDGE_OUT_BIT 1
`define EBR_STAT_DONE_BIT 2

// Clock output divider: last count of a half period, which lasts this value plus one core cycles.
`define EBR_SYSTEM_CLOCK_OUTPUT_HALF   4'h1

`endif

// ===== pkg/ebr_pkg.sv
package ebr_pkg;
   typedef enum logic [6:0] {
      EBR_IDLE = 7'h01,
      EBR_ADDR = 7'h02,
      EBR_WAIT = 7'h04,
      EBR_STRB = 7'h08,
      EBR_MUXW = 7'h10,
      EBR_TRIW = 7'h20,
      EBR_HOLD = 7'h40
   } ebr_state_e;

   typedef struct packed {
      logic        wr;
      logic [7:0]  adr;
      logic [15:0] dat;
   } ebr_cmd_s;
endpackage

// ===== pkg/ebr_rdy_if.sv
`timescale 1ns/1ps
interface ebr_rdy_if;
   logic rdy_pin;
   logic rdy_sync;
   logic async_mode;
   modport sync_end (input rdy_pin, input async_mode, output rdy_sync);
   modport user_end (output rdy_pin, output async_mode, input rdy_sync);
endinterface

// ===== rtl/ebr_ready_sync.sv
`timescale 1ns/1ps
`include "ebr_defines.svh"

// Ready conditioning. Synchronous ready passes one flip-flop here, then is sampled
// at the clock-output edge by the caller; asynchronous ready passes three flip-flops here.
module ebr_ready_sync (
   input  wire logic     core_clk,
   input  wire logic     arst_n,
   ebr_rdy_if.sync_end   rif
);
   logic s1_reg;
   logic s2_reg;
   logic s0_reg;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s0_reg <= 1'b1;
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
      end else begin
         s0_reg <= rif.rdy_pin;
         s1_reg <= s0_reg;
         s2_reg <= s1_reg;
      end
   end

   assign rif.rdy_sync = rif.async_mode ? s2_reg : s0_reg; // R11
endmodule

// ===== dv/ebr_mem_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// External responder: word memory with a ready handshake.
// ---------------------------------------------------------------
module ebr_mem_model (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic [7:0]  bus_addr,
   input  wire logic [15:0] bus_dout,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   input  wire logic        chip_select_outputs_n,
   input  wire logic [7:0]  lag,
   output logic [15:0]      bus_din,
   output logic             ready_n
);
   logic [15:0] mem [0:255];
   logic [7:0]  cnt_reg;
   logic [7:0]  adr_reg;
   logic [15:0] dat_reg;
   logic        wr_reg;
   wire         strb = !rd_n || !wr_n;

   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= 8'h00;
         ready_n <= 1'b1;
         wr_reg  <= 1'b1;
         bus_din <= 16'hFFFF;
         for (int i = 0; i < 256; i++) mem[i] <= 16'(i);
      end else begin
         wr_reg  <= wr_n;
         cnt_reg <= strb ? cnt_reg + 8'h01 : 8'h00;
         // Ready stays high for the lag, then low until the strobe rises again.
         ready_n <= !(strb && cnt_reg >= lag);
         if (!wr_n) begin
            adr_reg <= bus_addr;
            dat_reg <= bus_dout;
         end
         if (!wr_reg && wr_n) begin
            mem[adr_reg] <= dat_reg;
         end
         // A released data bus toggles so that a late latch is seen as wrong.
         bus_din <= (!rd_n && !chip_select_outputs_n) ? mem[bus_addr] : ~bus_din;
      end
   end
endmodule

// ===== dv/test_external_bus_ready_waitstate.sv
`timescale 1ns/1ps
`include "ebr_defines.svh"
module test_external_bus_ready_waitstate;
   logic        core_clk, link_clk, arst_n, psel, penable, pwrite, hold_n, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic        pready, pslverr, system_clock_output, bus_dout_oe, rd_n, wr_n, ale;
   logic        chip_select_outputs_n, ready_n, hold_acknowledge_out_n;
   logic        bus_regain_request_n, link_busy, seen_strb, hold_bad, link_seen;
   logic [7:0]  bus_addr, lag;
   logic [15:0] bus_dout, bus_din;
   int          fails, n_tests, lo_cnt, pre_cnt, cs_cnt, al_cnt, oe_cnt;

   ebr_ctrl uut (.core_clk, .arst_n, .link_clk, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .system_clock_output, .bus_addr, .bus_dout, .bus_dout_oe,
      .bus_din, .rd_n, .wr_n, .ale, .chip_select_outputs_n, .ready_n, .hold_n,
      .hold_acknowledge_out_n, .bus_regain_request_n, .link_busy);
   ebr_mem_model mem (.core_clk, .arst_n, .bus_addr, .bus_dout, .rd_n, .wr_n,
      .chip_select_outputs_n, .lag, .bus_din, .ready_n);

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      link_clk = 1'b0;
      #1.7;
      forever #3 link_clk = ~link_clk;
   end
   // ---------------------------------------------------------------
   // Monitors of the external bus.
   // ---------------------------------------------------------------
   always @(posedge core_clk) begin
      if (!rd_n || !wr_n) begin
         lo_cnt++;
         seen_strb = 1'b1;
      end else if (!chip_select_outputs_n && !seen_strb) begin
         pre_cnt++;
      end
      if (!chip_select_outputs_n) cs_cnt++;
      if (ale) al_cnt++;
      if (bus_dout_oe) oe_cnt++;
      if (!hold_acknowledge_out_n && !chip_select_outputs_n) hold_bad = 1'b1;
   end
   always @(posedge link_clk) begin
      if (link_busy === 1'b1) link_seen = 1'b1;
   end
   // ---------------------------------------------------------------
   // Shared tasks.
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("comparisons=%0d mismatches=%0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic keep = 1'b0);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      if (!keep) begin
         psel    <= 1'b0;
         penable <= 1'b0;
         @(posedge core_clk);
      end
   endtask
   task automatic wait_bit(input int b, input logic v);
      int i;
      for (i = 0; i < 300; i++) begin
         apb(1'b0, `EBR_STAT_OFS, 32'h0, 1'b1);
         if (r[b] === v) break;
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
      chk(32'(r[b]), 32'(v));
   endtask
   task automatic bus_op(input logic w, input logic [7:0] a, input logic [15:0] d,
                         input int b = 0, input logic v = 1'b0);
      lo_cnt    = 0;
      pre_cnt   = 0;
      cs_cnt    = 0;
      al_cnt    = 0;
      oe_cnt    = 0;
      seen_strb = 1'b0;
      apb(1'b1, `EBR_CMD_OFS, {d, 7'h00, w, a});
      wait_bit(b, v);
   endtask
   // ---------------------------------------------------------------
   // Scenarios.
   // ---------------------------------------------------------------
   task automatic t_regs;
      apb(1'b0, `EBR_CTRL_OFS, 32'h0);
      chk(r, `EBR_CTRL_RST);
      apb(1'b0, `EBR_STAT_OFS, 32'h0);
      chk(r, 32'h0);
      apb(1'b1, `EBR_CTRL_OFS, 32'h0000_00C5);
      apb(1'b0, `EBR_CTRL_OFS, 32'h0);
      chk(r, 32'h0000_00C5);
      apb(1'b0, 12'h010, 32'h0);
      chk(r, 32'h0);
      chk(32'(e), 32'h1);
      $display("t_regs done");
   endtask
   task automatic t_rw;
      apb(1'b1, `EBR_CTRL_OFS, 32'h0);
      lag <= 8'h00;
      bus_op(1'b1, 8'h5A, 16'hC3A5);
      chk(32'(mem.mem[8'h5A]), 32'h0000_C3A5);
      chk(32'(lo_cnt), 32'h4);
      chk(32'(al_cnt), 32'h4);
      chk(32'(oe_cnt), 32'h8);
      bus_op(1'b0, 8'h5A, 16'h0);
      chk(32'(oe_cnt), 32'h0);
      apb(1'b0, `EBR_RDATA_OFS, 32'h0);
      chk(r, 32'h0000_C3A5);
      chk(32'(link_seen), 32'h1);
      $display("t_rw done");
   endtask
   task automatic t_wait;
      int n[4] = '{0, 2, 1, 3};
      int x[4] = '{0, 0, 2, 1};
      int k;
      for (k = 0; k < 4; k++) begin
         apb(1'b1, `EBR_CTRL_OFS, 32'(n[k] + (k % 2) * 128));
         lag <= (x[k] == 0) ? 8'h00 : 8'(4 * (n[k] + x[k]) - 2);
         bus_op(1'b0, 8'h5A, 16'h0);
         chk(32'(lo_cnt), 32'(4 * (n[k] + x[k] + 1)));
      end
      $display("t_wait done");
   endtask
   task automatic t_rwd;
      int k;
      lag <= 8'h00;
      for (k = 0; k < 2; k++) begin
         apb(1'b1, `EBR_CTRL_OFS, 32'(k * 64));
         bus_op(1'b1, 8'h10, 16'h1234);
         chk(32'(pre_cnt), 32'(4 + 4 * k));
      end
      $display("t_rwd done");
   endtask
   task automatic t_mux;
      int t[3];
      int k;
      time t0;
      for (k = 0; k < 3; k++) begin
         apb(1'b1, `EBR_CTRL_OFS, (k == 0) ? 32'h0 : ((k == 1) ? 32'h10 : 32'h30));
         @(posedge system_clock_output);
         t0 = $time;
         bus_op(1'b0, 8'h10, 16'h0);
         t[k] = int'(($time - t0) / 40);
      end
      chk(32'(t[1] - t[0]), 32'h4);
      chk(32'(t[2] - t[0]), 32'h8);
      $display("t_mux done");
   endtask
   task automatic t_hold;
      int i;
      apb(1'b1, `EBR_CTRL_OFS, 32'h3);
      hold_bad = 1'b0;
      apb(1'b1, `EBR_CMD_OFS, 32'h0000_0021);
      for (i = 0; i < 100 && rd_n !== 1'b0; i++) @(posedge core_clk);
      hold_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk(32'(hold_acknowledge_out_n), 32'h1);
      for (i = 0; i < 200 && hold_acknowledge_out_n !== 1'b0; i++) @(posedge core_clk);
      chk(32'(hold_acknowledge_out_n), 32'h0);
      chk(32'(hold_bad), 32'h0);
      cs_cnt = 0;
      lo_cnt = 0;
      apb(1'b1, `EBR_CMD_OFS, 32'h0000_0022);
      repeat (20) @(posedge core_clk);
      chk(32'(bus_regain_request_n), 32'h0);
      chk(32'(cs_cnt), 32'h0);
      hold_n <= 1'b1;
      wait_bit(`EBR_STAT_DONE_BIT, 1'b1);
      chk(32'(lo_cnt), 32'h10);
      chk(32'(hold_acknowledge_out_n), 32'h1);
      $display("t_hold done");
   endtask

   initial begin
      arst_n    = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 12'h000;
      pwdata    = 32'h0;
      hold_n    = 1'b1;
      lag       = 8'h00;
      fails     = 0;
      n_tests   = 0;
      lo_cnt    = 0;
      pre_cnt   = 0;
      cs_cnt    = 0;
      seen_strb = 1'b0;
      hold_bad  = 1'b0;
      link_seen = 1'b0;
      repeat (12) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      t_regs();
      t_rw();
      t_wait();
      t_rwd();
      t_mux();
      t_hold();
      end_sim();
   end
   initial begin
      #2000000;
      fails++;
      end_sim();
   end
endmodule
